//--- verilog/fns_core_map.vh
`ifndef FNS_CORE_MAP_VH
`define FNS_CORE_MAP_VH

// ----------------------------------------
// Serial latch addresses
// ----------------------------------------
`define FNS_ADDR_F1 2'b00
`define FNS_ADDR_F2 2'b01
`define FNS_ADDR_REF 2'b10
`define FNS_ADDR_FB 2'b11

// ----------------------------------------
// Field positions in the 24-bit word
// ----------------------------------------
`define FNS_F1_FRAC16 22
`define FNS_F1_MUX_HI 21
`define FNS_F1_MUX_LO 19
`define FNS_F1_PWRDN 18
`define FNS_F1_POL 17
`define FNS_F1_CODE_HI 16
`define FNS_F1_CODE_LO 13
`define FNS_F1_PRE32 12
`define FNS_REF_DBL 20
`define FNS_REF_DIV_HI 16
`define FNS_REF_DIV_LO 2
`define FNS_FB_NUM_HI 20
`define FNS_FB_NUM_LO 17
`define FNS_FB_MAIN_HI 16
`define FNS_FB_MAIN_LO 7
`define FNS_FB_SWAL_HI 6
`define FNS_FB_SWAL_LO 2

// ----------------------------------------
// Reset values of the latches
// ----------------------------------------
`define FNS_RST_F1 24'h000000
`define FNS_RST_F2 24'h000001
`define FNS_RST_REF 24'h00000e
`define FNS_RST_FB 24'h008803

// ----------------------------------------
// Divider and multiplexer constants
// ----------------------------------------
`define FNS_REF_MIN 15'h0003
`define FNS_PRE_LO 6'h10
`define FNS_PRE_HI 6'h20
`define FNS_MOD_15 5'h0f
`define FNS_MOD_16 5'h10
`define FNS_MUX_DLOCK 3'h1
`define FNS_MUX_ALOCK 3'h2
`define FNS_MUX_REFOUT 3'h3
`define FNS_MUX_FBOUT 3'h4

// ----------------------------------------
// Lock filter timing
// ----------------------------------------
`define FNS_CLK_NS 8
`define FNS_LOCK_NS 15
`define FNS_LOCK_CYC ((`FNS_LOCK_NS + `FNS_CLK_NS - 1) / `FNS_CLK_NS)
`define FNS_LOCK_RUN 3'h5

// ----------------------------------------
// AXI4-Lite register map
// ----------------------------------------
`define FNS_AXI_F1 8'h00
`define FNS_AXI_F2 8'h04
`define FNS_AXI_REF 8'h08
`define FNS_AXI_FB 8'h0c
`define FNS_AXI_STAT 8'h10
`define FNS_AXI_CTRL 8'h14
`define FNS_RESP_OK 2'b00
`define FNS_RESP_ERR 2'b10

`endif

//--- verilog/fns_core.v
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`include "fns_core_map.vh"
`timescale 1ns/1ps
`default_nettype none

module fns_core (
    input wire clk_sys,
    input wire rstn,
    input wire ref_osc,
    input wire vco_in,
    input wire ser_clk,
    input wire ser_data,
    input wire load_strobe,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg pump_up,
    output reg pump_down,
    output reg pump_output_oe_n,
    output reg [3:0] pump_current_code,
    output reg doubler_enable,
    output reg multifunction_output
);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    reg [4:0] sync1;
    reg [4:0] sync2;
    reg [4:0] sync_prev;
    wire [4:0] rise = sync2 & ~sync_prev;
    wire ref_rise = rise[0];
    wire vco_rise = rise[1];
    wire ser_rise = rise[2];
    wire load_rise = rise[4];

    always @(posedge clk_sys) begin
        if (!rstn) begin
            sync1 <= 5'h00;
            sync2 <= 5'h00;
            sync_prev <= 5'h00;
        end else begin
            sync1 <= {load_strobe, ser_data, ser_clk, vco_in, ref_osc};
            sync2 <= sync1;
            sync_prev <= sync2;
        end
    end

    // ----------------------------------------
    // Serial port and latches
    // ----------------------------------------
    reg [23:0] shift;
    reg [23:0] lat_f1;
    reg [23:0] lat_f2;
    reg [23:0] lat_ref;
    reg [23:0] lat_fb;
    reg ctrl_pwrdn;

    // Loading stays live in power-down
    always @(posedge clk_sys) begin
        if (!rstn) begin
            shift <= 24'h000000;
            lat_f1 <= `FNS_RST_F1;
            lat_f2 <= `FNS_RST_F2;
            lat_ref <= `FNS_RST_REF;
            lat_fb <= `FNS_RST_FB;
        end else begin
            // first bit ends up on top
            if (ser_rise) begin
                shift <= {shift[22:0], sync2[3]};
            end
            if (load_rise) begin
                if (shift[1:0] == `FNS_ADDR_F1) begin
                    lat_f1 <= shift;
                end else if (shift[1:0] == `FNS_ADDR_F2) begin
                    lat_f2 <= shift;
                end else if (shift[1:0] == `FNS_ADDR_REF) begin
                    lat_ref <= shift;
                end else begin
                    lat_fb <= shift;
                end
            end
        end
    end

    // ----------------------------------------
    // Settings decoded from latches
    // ----------------------------------------
    wire frac16 = lat_f1[`FNS_F1_FRAC16];
    wire [2:0] mux_sel = lat_f1[`FNS_F1_MUX_HI:`FNS_F1_MUX_LO];
    wire pwrdn = lat_f1[`FNS_F1_PWRDN] | ctrl_pwrdn;
    wire polarity = lat_f1[`FNS_F1_POL];
    wire pre32 = lat_f1[`FNS_F1_PRE32];
    wire [14:0] ref_div = lat_ref[`FNS_REF_DIV_HI:`FNS_REF_DIV_LO];
    wire [3:0] frac_num = lat_fb[`FNS_FB_NUM_HI:`FNS_FB_NUM_LO];
    wire [9:0] main_load = lat_fb[`FNS_FB_MAIN_HI:`FNS_FB_MAIN_LO];
    wire [4:0] swal_load = lat_fb[`FNS_FB_SWAL_HI:`FNS_FB_SWAL_LO];

    // ----------------------------------------
    // Reference divider
    // ----------------------------------------
    reg [14:0] ref_cnt;
    reg ref_evt;
    wire [14:0] ref_eff = (ref_div < `FNS_REF_MIN) ? `FNS_REF_MIN : ref_div;

    always @(posedge clk_sys) begin
        if (!rstn || pwrdn) begin
            ref_cnt <= 15'h0000;
            ref_evt <= 1'b0;
        end else begin
            ref_evt <= 1'b0;
            if (ref_rise) begin
                if (ref_cnt >= ref_eff - 15'h0001) begin
                    ref_cnt <= 15'h0000;
                    ref_evt <= 1'b1;
                end else begin
                    ref_cnt <= ref_cnt + 15'h0001;
                end
            end
        end
    end

    // ----------------------------------------
    // Feedback divider with fractional swallow
    // ----------------------------------------
    reg [5:0] pre_cnt;
    reg [5:0] swal_cnt;
    reg [9:0] main_cnt;
    reg [3:0] acc;
    reg [3:0] dly_cnt;
    reg fb_pend;
    reg fb_evt;
    wire [5:0] pre_mod = pre32 ? `FNS_PRE_HI : `FNS_PRE_LO;
    // prescaler runs P+1 while swallow count left
    wire [5:0] pre_top = (swal_cnt != 6'h00) ? pre_mod : pre_mod - 6'h01;
    wire [4:0] frac_mod = frac16 ? `FNS_MOD_16 : `FNS_MOD_15;
    wire [4:0] acc_sum = {1'b0, acc} + {1'b0, frac_num};
    wire acc_ovf = acc_sum >= frac_mod;
    wire [4:0] acc_wrap = acc_sum - frac_mod;
    wire [3:0] acc_next = acc_ovf ? acc_wrap[3:0] : acc_sum[3:0];

    always @(posedge clk_sys) begin
        if (!rstn || pwrdn) begin
            pre_cnt <= 6'h00;
            swal_cnt <= {1'b0, swal_load};
            main_cnt <= main_load;
            acc <= 4'h0;
            dly_cnt <= 4'h0;
            fb_pend <= 1'b0;
            fb_evt <= 1'b0;
        end else begin
            fb_evt <= 1'b0;
            if (vco_rise) begin
                if (pre_cnt >= pre_top) begin
                    pre_cnt <= 6'h00;
                    if (main_cnt <= 10'h001) begin
                        // N = P*main + swallow, no gaps
                        main_cnt <= main_load;
                        // average is N plus num over modulus
                        swal_cnt <= {1'b0, swal_load} + {5'h00, acc_ovf};
                        acc <= acc_next;
                        dly_cnt <= acc_next;
                        fb_pend <= 1'b1;
                    end else begin
                        main_cnt <= main_cnt - 10'h001;
                        if (swal_cnt != 6'h00) begin
                            swal_cnt <= swal_cnt - 6'h01;
                        end
                    end
                end else begin
                    pre_cnt <= pre_cnt + 6'h01;
                end
            end
            if (fb_pend) begin
                if (dly_cnt == 4'h0) begin
                    fb_pend <= 1'b0;
                    fb_evt <= 1'b1;
                end else begin
                    dly_cnt <= dly_cnt - 4'h1;
                end
            end
        end
    end

    // ----------------------------------------
    // Phase detector and lock filter
    // ----------------------------------------
    reg ref_ahead;
    reg fb_ahead;
    reg [7:0] err_cnt;
    reg [2:0] good_cnt;
    reg dig_lock;
    reg ana_lock;
    wire ref_seen = ref_ahead | ref_evt;
    wire fb_seen = fb_ahead | fb_evt;
    wire cmp_done = ref_seen & fb_seen;
    wire pump_busy = ref_ahead | fb_ahead;

    always @(posedge clk_sys) begin
        if (!rstn || pwrdn) begin
            ref_ahead <= 1'b0;
            fb_ahead <= 1'b0;
            err_cnt <= 8'h00;
            good_cnt <= 3'h0;
            dig_lock <= 1'b0;
            ana_lock <= 1'b0;
        end else begin
            ref_ahead <= ref_seen & ~cmp_done;
            fb_ahead <= fb_seen & ~cmp_done;
            ana_lock <= ~pump_busy;
            if (cmp_done) begin
                err_cnt <= 8'h00;
                // error under 15 ns counts toward lock
                if (err_cnt < `FNS_LOCK_CYC) begin
                    if (good_cnt >= `FNS_LOCK_RUN - 3'h1) begin
                        good_cnt <= `FNS_LOCK_RUN;
                        dig_lock <= 1'b1;
                    end else begin
                        good_cnt <= good_cnt + 3'h1;
                    end
                end else begin
                    good_cnt <= 3'h0;
                    dig_lock <= 1'b0;
                end
            end else if (pump_busy && err_cnt != 8'hff) begin
                err_cnt <= err_cnt + 8'h01;
            end
        end
    end

    // ----------------------------------------
    // Pin outputs
    // ----------------------------------------
    always @(posedge clk_sys) begin
        if (!rstn) begin
            pump_up <= 1'b0;
            pump_down <= 1'b0;
            pump_output_oe_n <= 1'b1;
            pump_current_code <= 4'h0;
            doubler_enable <= 1'b0;
            multifunction_output <= 1'b0;
        end else begin
            pump_up <= ~pwrdn & (polarity ? ref_ahead : fb_ahead);
            pump_down <= ~pwrdn & (polarity ? fb_ahead : ref_ahead);
            pump_output_oe_n <= pwrdn | ~pump_busy;
            pump_current_code <= lat_f1[`FNS_F1_CODE_HI:`FNS_F1_CODE_LO];
            // doubler only from reference bit 20
            doubler_enable <= lat_ref[`FNS_REF_DBL];
            if (mux_sel == `FNS_MUX_DLOCK) begin
                multifunction_output <= dig_lock & ~pwrdn;
            end else if (mux_sel == `FNS_MUX_ALOCK) begin
                multifunction_output <= ana_lock & ~pwrdn;
            end else if (mux_sel == `FNS_MUX_REFOUT) begin
                multifunction_output <= ref_evt;
            end else if (mux_sel == `FNS_MUX_FBOUT) begin
                multifunction_output <= fb_evt;
            end else begin
                multifunction_output <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------
    // Decode kept inline: status bits must wake the process, not only the address
    reg [32:0] rd_word;
    always @* begin
        if (s_axi_araddr == `FNS_AXI_F1) begin
            rd_word = {1'b0, 8'h00, lat_f1};
        end else if (s_axi_araddr == `FNS_AXI_F2) begin
            rd_word = {1'b0, 8'h00, lat_f2};
        end else if (s_axi_araddr == `FNS_AXI_REF) begin
            rd_word = {1'b0, 8'h00, lat_ref};
        end else if (s_axi_araddr == `FNS_AXI_FB) begin
            rd_word = {1'b0, 8'h00, lat_fb};
        end else if (s_axi_araddr == `FNS_AXI_STAT) begin
            rd_word = {1'b0, 28'h0000000, pump_busy, pwrdn, ana_lock, dig_lock};
        end else if (s_axi_araddr == `FNS_AXI_CTRL) begin
            rd_word = {1'b0, 31'h00000000, ctrl_pwrdn};
        end else begin
            rd_word = {1'b1, 32'h00000000};
        end
    end

    // Only the control word is writable; latches belong to the serial port
    always @(posedge clk_sys) begin
        if (!rstn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `FNS_RESP_OK;
            ctrl_pwrdn <= 1'b0;
        end else if (s_axi_awready) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (s_axi_awaddr == `FNS_AXI_CTRL) begin
                s_axi_bresp <= `FNS_RESP_OK;
                if (s_axi_wstrb[0]) begin
                    ctrl_pwrdn <= s_axi_wdata[0];
                end
            end else begin
                s_axi_bresp <= `FNS_RESP_ERR;
            end
        end else if (s_axi_bvalid) begin
            if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end else if (s_axi_awvalid && s_axi_wvalid) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end
    end

    always @(posedge clk_sys) begin
        if (!rstn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `FNS_RESP_OK;
        end else if (s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word[31:0];
            s_axi_rresp <= rd_word[32] ? `FNS_RESP_ERR : `FNS_RESP_OK;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else if (s_axi_arvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

endmodule // fns_core

`default_nettype wire

//--- test/fns_core_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port checker
// ----------------------------------------
module fns_core_checker (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic load_strobe,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic pump_up,
    input wire logic pump_down,
    input wire logic pump_output_oe_n,
    input wire logic [3:0] pump_current_code,
    input wire logic doubler_enable,
    input wire logic multifunction_output
);
    logic ls_q;
    logic [3:0] ls_age;
    // Age of the last raw strobe rise; covers the sync delay
    always @(posedge clk_sys) begin
        ls_q <= load_strobe;
        if (!rstn) begin
            ls_age <= 4'hf;
        end else if (load_strobe && !ls_q) begin
            ls_age <= 4'h0;
        end else if (ls_age != 4'hf) begin
            ls_age <= ls_age + 4'h1;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    reset_quiet_a: assert property (disable iff (1'b0)
        !rstn |=> pump_output_oe_n && !doubler_enable && !multifunction_output)
        else $error("outputs not quiet after reset");
    pump_drive_a: assert property ((pump_up || pump_down) == !pump_output_oe_n)
        else $error("pump enable does not match pump commands");
    code_load_a: assert property ($changed(pump_current_code) |-> ls_age <= 4'hc)
        else $error("pump code moved without a load");
    doubler_load_a: assert property ($changed(doubler_enable) |-> ls_age <= 4'hc)
        else $error("doubler moved without a load");
    write_accept_a: assert property (s_axi_awready |-> s_axi_wready ##1
        (!s_axi_awready && s_axi_bvalid)) else $error("write handshake out of step");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    bresp_code_a: assert property (s_axi_bvalid |-> s_axi_bresp[0] == 1'b0)
        else $error("write response code illegal");
    read_answer_a: assert property (s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    read_refuse_a: assert property (s_axi_rvalid && s_axi_rresp != 2'b00 |->
        s_axi_rdata == 32'h0) else $error("refused read carries data");
endmodule // fns_core_checker
bind fns_core fns_core_checker u_fns_core_checker (.clk_sys, .rstn, .load_strobe,
    .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .pump_up,
    .pump_down, .pump_output_oe_n, .pump_current_code, .doubler_enable,
    .multifunction_output);
`default_nettype wire

//--- test/fns_host.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Serial host model
// ----------------------------------------
module fns_host (
    output logic ser_clk,
    output logic ser_data,
    output logic load_strobe
);
    initial begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        load_strobe = 1'b0;
    end
    task automatic send(input logic [23:0] word);
        for (int i = 23; i >= 0; i--) begin
            ser_data = word[i];
            #30 ser_clk = 1'b1;
            #40 ser_clk = 1'b0;
            #10;
        end
        // Data no longer held, so show the inverse
        ser_data = ~word[0];
        #50 load_strobe = 1'b1;
        #80 load_strobe = 1'b0;
    endtask
endmodule // fns_host
`default_nettype wire

//--- test/test_fns_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "fns_core_map.vh"
module test_fns_core;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic ref_osc = 1'b0;
    logic vco_in = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    wire ser_clk, ser_data, load_strobe, s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire s_axi_arready, s_axi_rvalid, pump_up, pump_down, pump_output_oe_n;
    wire doubler_enable, multifunction_output;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [3:0] pump_current_code;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;
    int ref_half = 3, vco_half = 3, ref_cnt = 1, vco_cnt = 1, n;
    logic gen_on = 1'b0;
    logic [31:0] rd;
    logic [1:0] rr;
    logic [2:0] saw;
    logic oe_q;
    int gap;
    logic [23:0] rst_val [4] = '{`FNS_RST_F1, `FNS_RST_F2, `FNS_RST_REF, `FNS_RST_FB};
    // Lock detect on output, pump max, ratio 272 on both dividers
    logic [23:0] words [4] = '{24'h0be000, 24'ha5a5a5, 24'h100442, 24'h000883};

    always #4 clk_sys = ~clk_sys;

    fns_core u_fns_core (.clk_sys, .rstn, .ref_osc, .vco_in, .ser_clk, .ser_data,
        .load_strobe, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pump_up, .pump_down,
        .pump_output_oe_n, .pump_current_code, .doubler_enable, .multifunction_output);
    fns_host u_fns_host (.ser_clk, .ser_data, .load_strobe);

    // ----------------------------------------
    // Oscillators and watchdog
    // ----------------------------------------
    // Both made from the same edges so the dividers start aligned
    always @(posedge clk_sys) begin
        ref_cnt <= (gen_on && ref_cnt < ref_half) ? ref_cnt + 1 : 1;
        vco_cnt <= (gen_on && vco_cnt < vco_half) ? vco_cnt + 1 : 1;
        ref_osc <= gen_on & (ref_osc ^ (ref_cnt == ref_half));
        vco_in <= gen_on & (vco_in ^ (vco_cnt == vco_half));
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            miscompares++;
            conclude();
        end
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task reg_check(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] rexp);
        axi_read(a, rd, rr);
        check_val($sformatf("rdata %h", a), exp, rd);
        check_val($sformatf("rresp %h", a), 32'(rexp), 32'(rr));
    endtask
    task wait_mfo(input logic lvl, input int limit);
        n = 0;
        while (multifunction_output !== lvl && n < limit) begin
            @(posedge clk_sys);
            n++;
        end
    endtask
    // Period of k pulses on the output, after one pulse to settle
    task pulse_gap(input int k);
        wait_mfo(1'b1, 20000);
        gap = 0;
        repeat (k) begin
            @(posedge clk_sys);
            wait_mfo(1'b1, 20000);
            gap += n + 1;
        end
    endtask
    task load(input logic [23:0] w);
        u_fns_host.send(w);
        repeat (12) @(posedge clk_sys);
    endtask
    task conclude;
        if (miscompares == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        #1;
        check_val("code", 32'h0, 32'(pump_current_code));
        check_val("oe_n", 32'h1, 32'(pump_output_oe_n));
        check_val("doubler", 32'h0, 32'(doubler_enable));
        for (int i = 0; i < 4; i++) reg_check(8'(4 * i), 32'(rst_val[i]), 2'b00);
        for (int i = 0; i < 4; i++) load(words[i]);
        for (int i = 0; i < 4; i++) reg_check(8'(4 * i), 32'(words[i]), 2'b00);
        check_val("code", 32'hf, 32'(pump_current_code));
        check_val("doubler", 32'h1, 32'(doubler_enable));
        reg_check(8'h18, 32'h0, `FNS_RESP_ERR);
        axi_write(`FNS_AXI_F1, 32'hffffffff, rr);
        check_val("bresp", 32'(`FNS_RESP_ERR), 32'(rr));
        reg_check(`FNS_AXI_F1, 32'(words[0]), `FNS_RESP_OK);
        gen_on <= 1'b1;
        axi_write(`FNS_AXI_CTRL, 32'h1, rr);
        check_val("bresp", 32'(`FNS_RESP_OK), 32'(rr));
        load(24'h000442);
        reg_check(`FNS_AXI_REF, 32'h000442, `FNS_RESP_OK);
        axi_read(`FNS_AXI_STAT, rd, rr);
        check_val("status", 32'h4, rd & 32'h5);
        check_val("mfo", 32'h0, 32'(multifunction_output));
        check_val("oe_n", 32'h1, 32'(pump_output_oe_n));
        check_val("doubler", 32'h0, 32'(doubler_enable));
        // Fifth good comparison lands near 8160 cycles after release
        axi_write(`FNS_AXI_CTRL, 32'h0, rr);
        wait_mfo(1'b1, 16000);
        check_val("lock wait", 32'h1, 32'(n >= 6528 && n < 16000));
        axi_read(`FNS_AXI_STAT, rd, rr);
        check_val("status", 32'h1, rd & 32'h5);
        ref_half <= 4;
        wait_mfo(1'b0, 8000);
        check_val("unlock", 32'h1, 32'(n < 8000));
        // Feedback now leads: one pump direction only, set by polarity
        for (int p = 1; p >= 0; p--) begin
            load((words[0] & 24'hfdffff) | (24'(p) << 17));
            repeat (3000) @(posedge clk_sys);
            saw = 3'b000;
            repeat (6000) begin
                @(posedge clk_sys);
                saw = saw | {pump_up, pump_down, !pump_output_oe_n};
            end
            check_val("pump dir", p ? 32'h3 : 32'h5, 32'(saw));
        end
        // Latch power-down bit, analog lock selected
        load(24'h140000);
        saw = 3'b000;
        repeat (1000) begin
            @(posedge clk_sys);
            saw = saw | {multifunction_output, !pump_output_oe_n, 1'b0};
        end
        check_val("pwrdn bit", 32'h0, 32'(saw));
        // Output register adds one cycle behind the pump enable
        load(24'h100000);
        saw = 3'b000;
        oe_q = pump_output_oe_n;
        repeat (4352) begin
            @(posedge clk_sys);
            saw = saw | {multifunction_output, !multifunction_output,
                multifunction_output !== oe_q};
            oe_q = pump_output_oe_n;
        end
        check_val("analog lock", 32'h6, 32'(saw));
        load(24'h180000);
        pulse_gap(2);
        check_val("ref period", 32'd4352, 32'(gap));
        load(24'h200000);
        pulse_gap(2);
        check_val("fb period", 32'd3264, 32'(gap));
        load(24'h1e0883);
        pulse_gap(2);
        check_val("mod 15", 32'd3276, 32'(gap));
        load(24'h600000);
        load(24'h100883);
        pulse_gap(2);
        check_val("mod 16", 32'd3270, 32'(gap));
        load(24'h601000);
        load(24'h001097);
        pulse_gap(1);
        check_val("pre 32", 32'd6366, 32'(gap));
        conclude();
    end
endmodule // test_fns_core
`default_nettype wire
